// ==== inc/fes_pkg.sv ====
// constants and types for the flash erase/program host controller
`default_nettype none
package fes_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_SETUP_ERASE = 16'h0080;
  localparam logic [15:0] CMD_CHIP = 16'h0010;
  localparam logic [15:0] CMD_SECTOR = 16'h0030;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_ABORT = 16'h00f0;
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2aa;
  // status bit positions on the flash data lines
  localparam int DATA_POLL_BIT = 7;
  localparam int TOGGLE_BIT_ONE = 6;
  localparam int TIMEOUT_FLAG_BIT = 5;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  // status register field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_WINDOW = 5;
  localparam int ST_READY = 6;
  localparam logic [16:0] ADDR_RST = 17'h00000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROGRAM = 3'h1, OP_CHIP = 3'h2, OP_SECTOR = 3'h3,
    OP_ADD = 3'h4, OP_SUSPEND = 3'h5, OP_RESUME = 3'h6, OP_WAIT = 3'h7
  } fes_op_t;
  // pin timing, least times rounded up to whole cycles
  localparam int CLK_NS = 4;
  localparam int T_SETUP_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_HOLD_NS = 10;
  localparam int T_ACC_NS = 70;
  localparam int SYNC_CYC = 2;
  localparam logic [4:0] SETUP_CYC = 5'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] WP_CYC = 5'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] HOLD_CYC = 5'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] READ_CYC =
    5'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  // sector load window, a longest time so it rounds down
  localparam int T_WINDOW_US = 30;
  localparam int WINDOW_CYC_DEF = T_WINDOW_US * 1000 / CLK_NS;
  localparam int LEAD_CYC = int'(SETUP_CYC) + 4;
endpackage : fes_pkg
`default_nettype wire

// ==== inc/fes_cyc_if.sv ====
// one flash bus cycle request between sequencer and pin engine
`default_nettype none
interface fes_cyc_if;
  logic req;
  logic wr;
  logic [16:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic weRise;
  modport ctl (output req, wr, addr, wdata, input ack, rdata, weRise);
  modport pin (input req, wr, addr, wdata, output ack, rdata, weRise);
endinterface : fes_cyc_if
`default_nettype wire

// ==== hw/fes_pin_cycle.sv ====
// pin engine: runs one timed read or write cycle on the flash pins
`default_nettype none
module fes_pin_cycle
  import fes_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  fes_cyc_if.pin cyc,
  output logic [16:0] flashAddr,
  output logic [15:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [15:0] flashDqIn,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN
);
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01, PH_SETUP = 5'h02, PH_PULSE = 5'h04,
    PH_HOLD = 5'h08, PH_GAP = 5'h10
  } fes_ph_t;
  fes_ph_t ph_q, ph_d;
  logic [4:0] cnt_q, cnt_d;
  logic [16:0] addr_q, addr_d;
  logic [15:0] dq_q, dq_d, rdata_q, rdata_d, dqMeta_q, dqSync_q;
  logic dqOe_q, dqOe_d, wr_q, wr_d, ceN_q, ceN_d, oeN_q, oeN_d;
  logic weN_q, weN_d, ack_q, ack_d, weRise_q, weRise_d;

  // address is set as chip enable falls, ahead of the strobe by the setup time; data is held past the rise by the hold time
  always_comb begin
    ph_d = ph_q;
    cnt_d = (cnt_q == 5'h00) ? cnt_q : 5'(cnt_q - 5'h01);
    addr_d = addr_q;
    dq_d = dq_q;
    dqOe_d = dqOe_q;
    wr_d = wr_q;
    ceN_d = ceN_q;
    oeN_d = oeN_q;
    weN_d = weN_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    weRise_d = 1'b0;
    case (ph_q)
      PH_IDLE: begin
        if (cyc.req) begin
          addr_d = cyc.addr;
          dq_d = cyc.wdata;
          dqOe_d = cyc.wr;
          wr_d = cyc.wr;
          ceN_d = 1'b0;
          cnt_d = SETUP_CYC;
          ph_d = PH_SETUP;
        end
      end
      PH_SETUP: begin
        if (cnt_q == 5'h00) begin
          weN_d = !wr_q;
          oeN_d = wr_q;
          cnt_d = wr_q ? WP_CYC : READ_CYC;
          ph_d = PH_PULSE;
        end
      end
      PH_PULSE: begin
        if (cnt_q == 5'h00) begin
          weN_d = 1'b1;
          oeN_d = 1'b1;
          weRise_d = wr_q;
          if (!wr_q) begin
            rdata_d = dqSync_q;
          end
          cnt_d = HOLD_CYC;
          ph_d = PH_HOLD;
        end
      end
      PH_HOLD: begin
        if (cnt_q == 5'h00) begin
          ceN_d = 1'b1;
          dqOe_d = 1'b0;
          ack_d = 1'b1;
          ph_d = PH_GAP;
        end
      end
      PH_GAP: ph_d = PH_IDLE; // lets the sequencer drop its request
      default: ph_d = PH_IDLE;
    endcase
  end

  // registers; data lines pass two flops before anyone samples them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= PH_IDLE;
      cnt_q <= 5'h00;
      addr_q <= ADDR_RST;
      dq_q <= DATA_RST;
      rdata_q <= DATA_RST;
      dqMeta_q <= DATA_RST;
      dqSync_q <= DATA_RST;
      dqOe_q <= 1'b0;
      wr_q <= 1'b0;
      ceN_q <= 1'b1;
      oeN_q <= 1'b1;
      weN_q <= 1'b1;
      ack_q <= 1'b0;
      weRise_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      rdata_q <= rdata_d;
      dqMeta_q <= flashDqIn;
      dqSync_q <= dqMeta_q;
      dqOe_q <= dqOe_d;
      wr_q <= wr_d;
      ceN_q <= ceN_d;
      oeN_q <= oeN_d;
      weN_q <= weN_d;
      ack_q <= ack_d;
      weRise_q <= weRise_d;
    end
  end

  assign flashAddr = addr_q;
  assign flashDqOut = dq_q;
  assign flashDqOe = dqOe_q;
  assign flashCeN = ceN_q;
  assign flashOeN = oeN_q;
  assign flashWeN = weN_q;
  assign cyc.ack = ack_q;
  assign cyc.rdata = rdata_q;
  assign cyc.weRise = weRise_q;
endmodule : fes_pin_cycle
`default_nettype wire

// ==== hw/fes_window_timer.sv ====
// sector load window timer, restarted by each sector write strobe rise
`default_nettype none
module fes_window_timer
  import fes_pkg::*;
#(
  parameter int WINDOW_CYC = WINDOW_CYC_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic restart,
  input wire logic close,
  output logic open
);
  // close early by the lead so the next strobe still falls inside
  localparam logic [12:0] LIMIT = 13'(WINDOW_CYC - LEAD_CYC);
  logic [12:0] cnt_q, cnt_d;
  logic run_q, run_d;

  // any other write ends the window at once
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (restart) begin
      cnt_d = 13'h0000;
      run_d = 1'b1;
    end else if (close) begin
      run_d = 1'b0;
    end else if (run_q) begin
      if (cnt_q >= LIMIT) begin
        run_d = 1'b0;
      end else begin
        cnt_d = 13'(cnt_q + 13'h0001);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 13'h0000;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign open = run_q;
endmodule : fes_window_timer
`default_nettype wire

// ==== hw/fes_flash_host.sv ====
// flash host controller: wishbone registers, command sequencer, polling
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`default_nettype none
module fes_flash_host
  import fes_pkg::*;
#(
  parameter int WINDOW_CYC = WINDOW_CYC_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [16:0] flashAddr,
  output logic [15:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [15:0] flashDqIn,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  input wire logic readyBusyIn
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_SEND = 4'h2, ST_POLL = 4'h4, ST_ABORT = 4'h8
  } fes_st_t;

  fes_cyc_if cyc ();

  fes_st_t state_q, state_d;
  fes_op_t op_q, op_d, opStart;
  logic [2:0] step_q, step_d;
  logic [16:0] addr_q, addr_d, cycAddr_q, cycAddr_d;
  logic [15:0] data_q, data_d, rdata_q, rdata_d;
  logic [15:0] cycData_q, cycData_d, first_q, first_d;
  logic req_q, req_d, cycWr_q, cycWr_d;
  logic done_q, done_d, fail_q, fail_d, tmo_q, tmo_d;
  logic refused_q, refused_d, recheck_q, recheck_d;
  logic second_q, second_d;
  logic ack_q, ack_d;
  logic [31:0] datO_q, datO_d, wrMerged, status, adrMerged, datMerged;
  logic ryMeta_q, rySync_q;
  logic wbHit, wbWrite, winOpen, winRestart, winClose;
  logic steady, pollOk, tmoSeen;

  // last step index of each order's write list
  function automatic logic [2:0] lastStep(input fes_op_t op);
    case (op)
      OP_PROGRAM: lastStep = 3'h3;
      OP_CHIP, OP_SECTOR: lastStep = 3'h5;
      default: lastStep = 3'h0;
    endcase
  endfunction

  // address and data of each step, unlocks on the fixed low addresses
  function automatic logic [32:0] seqWord(input fes_op_t op,
      input logic [2:0] step, input logic [16:0] a, input logic [15:0] d);
    logic [16:0] u1;
    logic [16:0] u2;
    u1 = {6'h0, UNLOCK_ADDR1};
    u2 = {6'h0, UNLOCK_ADDR2};
    seqWord = {a, d};
    case (op)
      OP_READ: seqWord = {a, DATA_RST};
      OP_ADD: seqWord = {a, CMD_SECTOR};
      OP_SUSPEND: seqWord = {a, CMD_SUSPEND};
      OP_RESUME: seqWord = {a, CMD_RESUME};
      default: begin
        case (step)
          3'h0, 3'h3: seqWord = {u1, CMD_UNLOCK1};
          3'h1, 3'h4: seqWord = {u2, CMD_UNLOCK2};
          3'h2: seqWord = {u1, (op == OP_PROGRAM) ? CMD_PROGRAM
                                                   : CMD_SETUP_ERASE};
          default: seqWord = {u1, CMD_CHIP};
        endcase
        if (op == OP_PROGRAM && step == 3'h3) begin
          seqWord = {a, d};
        end
        if (op == OP_SECTOR && step == 3'h5) begin
          seqWord = {a, CMD_SECTOR};
        end
      end
    endcase
  endfunction

  // byte-lane merge of a wishbone write into a register image
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    laneMerge = old;
  endfunction

  fes_pin_cycle u_pin (
    .clk(clk),
    .nrst(nrst),
    .cyc(cyc.pin),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN)
  );

  // only a sector command strobe re-arms the load window
  assign winRestart = cyc.weRise && cycData_q == CMD_SECTOR &&
                      (op_q == OP_SECTOR || op_q == OP_ADD);
  assign winClose = cyc.weRise && !winRestart;

  fes_window_timer #(.WINDOW_CYC(WINDOW_CYC)) u_win (
    .clk(clk),
    .nrst(nrst),
    .restart(winRestart),
    .close(winClose),
    .open(winOpen)
  );

  assign cyc.req = req_q;
  assign cyc.wr = cycWr_q;
  assign cyc.addr = cycAddr_q;
  assign cyc.wdata = cycData_q;

  // wishbone decode; ack comes one cycle after the strobe
  assign wbHit = wb_cyc_i && wb_stb_i && !ack_q;
  assign wbWrite = wbHit && wb_we_i;
  assign wrMerged = laneMerge(32'h00000000, wb_dat_i, wb_sel_i);
  assign opStart = fes_op_t'(wrMerged[2:0]);
  // lane merges against the current images, selected by the decode below
  assign adrMerged = laneMerge({15'h0, addr_q}, wb_dat_i, wb_sel_i);
  assign datMerged = laneMerge({16'h0000, data_q}, wb_dat_i, wb_sel_i);
  assign status = {25'h0, rySync_q, winOpen, refused_q, tmo_q,
                   fail_q, done_q, state_q != ST_IDLE};

  // poll evaluation on the second of two reads
  assign steady = cyc.rdata[TOGGLE_BIT_ONE] == first_q[TOGGLE_BIT_ONE];
  assign pollOk = (op_q == OP_PROGRAM)
    ? cyc.rdata[DATA_POLL_BIT:TOGGLE_BIT_ONE] ==
      data_q[DATA_POLL_BIT:TOGGLE_BIT_ONE]
    : cyc.rdata[DATA_POLL_BIT];
  assign tmoSeen = cyc.rdata[TIMEOUT_FLAG_BIT] || first_q[TIMEOUT_FLAG_BIT];

  // register file, sequencer and poll loop
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    step_d = step_q;
    addr_d = addr_q;
    data_d = data_q;
    rdata_d = rdata_q;
    cycAddr_d = cycAddr_q;
    cycData_d = cycData_q;
    cycWr_d = cycWr_q;
    req_d = req_q;
    first_d = first_q;
    second_d = second_q;
    recheck_d = recheck_q;
    done_d = done_q;
    fail_d = fail_q;
    tmo_d = tmo_q;
    refused_d = refused_q;
    ack_d = wbHit;
    datO_d = datO_q;
    if (wbHit && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: datO_d = {29'h0, op_q};
        REG_ADDR: datO_d = {15'h0, addr_q};
        REG_DATA: datO_d = {16'h0000, rdata_q};
        REG_STATUS: datO_d = status;
        default: datO_d = 32'h00000000;
      endcase
    end
    if (wbWrite && state_q == ST_IDLE) begin
      case (wb_adr_i)
        REG_ADDR: addr_d = adrMerged[16:0];
        REG_DATA: data_d = datMerged[15:0];
        default: ;
      endcase
    end
    if (wbWrite && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      if (state_q != ST_IDLE || (opStart == OP_ADD && !winOpen)) begin
        refused_d = 1'b1;
      end else begin
        op_d = opStart;
        step_d = 3'h0;
        done_d = 1'b0;
        fail_d = 1'b0;
        tmo_d = 1'b0;
        refused_d = 1'b0;
        second_d = 1'b0;
        recheck_d = 1'b0;
        state_d = (opStart == OP_WAIT) ? ST_POLL : ST_SEND;
      end
    end
    case (state_q)
      ST_IDLE: ;
      ST_SEND: begin
        if (!req_q) begin
          {cycAddr_d, cycData_d} = seqWord(op_q, step_q, addr_q, data_q);
          cycWr_d = (op_q != OP_READ);
          req_d = 1'b1;
        end else if (cyc.ack) begin
          req_d = 1'b0;
          if (step_q != lastStep(op_q)) begin
            step_d = 3'(step_q + 3'h1);
          end else begin
            case (op_q)
              OP_PROGRAM, OP_CHIP, OP_RESUME: state_d = ST_POLL;
              default: begin
                rdata_d = (op_q == OP_READ) ? cyc.rdata : rdata_q;
                done_d = 1'b1;
                state_d = ST_IDLE;
              end
            endcase
          end
        end
      end
      ST_POLL: begin
        if (!req_q) begin
          cycAddr_d = addr_q;
          cycWr_d = 1'b0;
          req_d = 1'b1;
        end else if (cyc.ack) begin
          req_d = 1'b0;
          rdata_d = cyc.rdata;
          first_d = cyc.rdata;
          second_d = !second_q;
          if (second_q) begin
            if (steady) begin
              done_d = pollOk;
              state_d = pollOk ? ST_IDLE : ST_ABORT;
            end else if (tmoSeen) begin
              // one more pair: toggling may stop as the flag rises
              recheck_d = 1'b1;
              tmo_d = recheck_q;
              state_d = recheck_q ? ST_ABORT : ST_POLL;
            end
          end
        end
      end
      ST_ABORT: begin
        if (!req_q) begin
          cycAddr_d = addr_q;
          cycData_d = CMD_ABORT;
          cycWr_d = 1'b1;
          req_d = 1'b1;
        end else if (cyc.ack) begin
          req_d = 1'b0;
          fail_d = 1'b1;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // registers; ready/busy pin is brought in through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      op_q <= OP_READ;
      step_q <= 3'h0;
      addr_q <= ADDR_RST;
      data_q <= DATA_RST;
      rdata_q <= DATA_RST;
      cycAddr_q <= ADDR_RST;
      cycData_q <= DATA_RST;
      cycWr_q <= 1'b0;
      req_q <= 1'b0;
      first_q <= DATA_RST;
      second_q <= 1'b0;
      recheck_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tmo_q <= 1'b0;
      refused_q <= 1'b0;
      ack_q <= 1'b0;
      datO_q <= 32'h00000000;
      ryMeta_q <= 1'b0;
      rySync_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      step_q <= step_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rdata_q <= rdata_d;
      cycAddr_q <= cycAddr_d;
      cycData_q <= cycData_d;
      cycWr_q <= cycWr_d;
      req_q <= req_d;
      first_q <= first_d;
      second_q <= second_d;
      recheck_q <= recheck_d;
      done_q <= done_d;
      fail_q <= fail_d;
      tmo_q <= tmo_d;
      refused_q <= refused_d;
      ack_q <= ack_d;
      datO_q <= datO_d;
      ryMeta_q <= readyBusyIn;
      rySync_q <= ryMeta_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = datO_q;

  // checks on the command stream the host produces
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_chip_seq;
    (req_q && cycWr_q && state_q == ST_SEND && cycData_q == CMD_CHIP &&
     !(op_q == OP_PROGRAM && step_q == 3'h3))
      |-> (op_q == OP_CHIP && step_q == 3'h5 &&
           cycAddr_q[10:0] == UNLOCK_ADDR1);
  endproperty
  a_chip_seq: assert property (p_chip_seq)
    else $error("chip erase command outside sixth step");

  property p_sector_seq;
    (req_q && state_q == ST_SEND && op_q == OP_SECTOR && step_q == 3'h5)
      |-> (cycData_q == CMD_SECTOR && cycAddr_q == addr_q);
  endproperty
  a_sector_seq: assert property (p_sector_seq)
    else $error("sector erase last write wrong");

  property p_add_window;
    (wbWrite && wb_adr_i == REG_CTRL && state_q == ST_IDLE &&
     state_d == ST_SEND && opStart == OP_ADD) |-> winOpen;
  endproperty
  a_add_window: assert property (p_add_window)
    else $error("sector added after load window closed");

  property p_poll_addr;
    (state_q == ST_POLL && req_q) |-> (cycAddr_q == addr_q && !cycWr_q);
  endproperty
  a_poll_addr: assert property (p_poll_addr)
    else $error("status poll at wrong address");

  property p_prog_data;
    (cyc.ack && req_q && state_q == ST_SEND && op_q == OP_PROGRAM &&
     step_q == 3'h2) |=> ##1 (req_q && cycAddr_q == addr_q &&
     cycData_q == data_q && $past(cycData_q, 2) == CMD_PROGRAM);
  endproperty
  a_prog_data: assert property (p_prog_data)
    else $error("program data write does not follow A0H");

  property p_unlock_addr;
    (req_q && cycWr_q && state_q == ST_SEND &&
     !(op_q == OP_PROGRAM && step_q == 3'h3) &&
     (cycData_q == CMD_UNLOCK1 || cycData_q == CMD_UNLOCK2))
      |-> (cycAddr_q[10:0] == UNLOCK_ADDR1 ||
           cycAddr_q[10:0] == UNLOCK_ADDR2);
  endproperty
  a_unlock_addr: assert property (p_unlock_addr)
    else $error("unlock write at wrong address");

  property p_abort;
    (state_q == ST_POLL && state_d == ST_ABORT)
      |=> ##1 (req_q && cycWr_q && cycData_q == CMD_ABORT);
  endproperty
  a_abort: assert property (p_abort)
    else $error("failure not followed by abort write");

  property p_cov_prog;
    (state_q == ST_POLL && op_q == OP_PROGRAM) ##1 state_q == ST_IDLE;
  endproperty
  c_cov_prog: cover property (p_cov_prog);

  property p_cov_chip;
    (state_q == ST_SEND && op_q == OP_CHIP) ##1 state_q == ST_POLL;
  endproperty
  c_cov_chip: cover property (p_cov_chip);

  property p_cov_abort;
    (state_q == ST_ABORT && cyc.ack);
  endproperty
  c_cov_abort: cover property (p_cov_abort);
endmodule : fes_flash_host
`default_nettype wire

// ==== bench/fes_flash_model.sv ====
// behavioural flash device facing the host controller pins
`default_nettype none
module fes_flash_model
  import fes_pkg::*;
(
  input wire logic [16:0] a,
  input wire logic [15:0] d,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic stuck,
  output logic [15:0] q,
  output logic rb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:15];
  logic [15:0] pd, last;
  logic [16:0] la;
  logic [2:0] s;
  logic er, tg, sus;
  int bc;
  wire logic un = (a[10:0] == UNLOCK_ADDR1);
  initial begin
    s = 0; bc = 0; tg = 0; er = 0; pd = 0; last = 16'h0000; sus = 0;
    for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
  end
  // address is taken on the strobe fall, as the device does
  always @(negedge weN) if (!ceN) la = a;
  // commands decode on strobe rise, so address and data are both settled
  always @(posedge weN) if (!ceN) begin
    if (d == CMD_ABORT) begin bc = 0; s = 0; end
    else if (d == CMD_SUSPEND && er && bc > 0) sus = 1;
    else if (sus && d == CMD_RESUME) sus = 0;
    else if (s == 3'd3) begin
      mem[la[3:0]] = d; pd = d; bc = 3; er = 0; s = 0;
    end
    else if ((s == 0 || s == 4) && un && d == CMD_UNLOCK1) s = s + 1;
    else if ((s == 1 || s == 5) && a[10:0] == UNLOCK_ADDR2 &&
      d == CMD_UNLOCK2) s = s + 1;
    else if (s == 2 && un && d == CMD_PROGRAM) s = 3;
    else if (s == 2 && un && d == CMD_SETUP_ERASE) s = 4;
    else if (s == 6 && ((un && d == CMD_CHIP) || d == CMD_SECTOR)) begin
      for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
      bc = 5; er = 1; s = 0;
    end
    else s = 0;
  end
  // status while busy, array data once the operation ends
  always @(negedge oeN) if (!ceN) begin
    if (bc > 0) begin
      tg = ~tg;
      last = 16'h0000;
      last[TOGGLE_BIT_ONE] = tg;
      last[DATA_POLL_BIT] = er ? 1'b0 : ~pd[7];
      last[TIMEOUT_FLAG_BIT] = stuck;
      if (!stuck) bc = bc - 1;
    end
    else last = mem[a[3:0]];
  end
  // a released bus shows the inverse, so stale data never passes
  assign q = (oeN || ceN) ? ~last : last;
  // a suspended erase leaves the pin released high
  assign rb = (bc == 0) || sus;
endmodule // fes_flash_model
`default_nettype wire

// ==== bench/fes_flash_host_test.sv ====
// self-checking bench for the flash host controller
`default_nettype none
module fes_flash_host_test
  import fes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, cyc, stb, we, stuck, ack, ceN, oeN, weN, dqOe, rb;
  logic [3:0] adr;
  logic [31:0] wdat, rd, dato;
  logic [16:0] fa;
  logic [15:0] dqOut, mq;
  int bad_count, tests_run;
  wire logic [15:0] dq = dqOe ? dqOut : mq;
  fes_flash_host #(.WINDOW_CYC(200)) i_dut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
    .wb_dat_o(dato), .wb_ack_o(ack), .flashAddr(fa),
    .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dq),
    .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .readyBusyIn(rb)
  );
  fes_flash_model i_fl (
    .a(fa), .d(dq), .ceN(ceN), .oeN(oeN), .weN(weN), .stuck(stuck),
    .q(mq), .rb(rb)
  );
  // 250 MHz clock
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle; read data lands in rd
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dato;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  // start an operation and poll status until busy drops
  task run(input logic [2:0] op);
    wb(1'b1, REG_CTRL, {29'h0, op});
    rd = 32'h1;
    for (int i = 0; i < 4000 && rd[ST_BUSY] !== 1'b0; i++)
      wb(1'b0, REG_STATUS, 32'h0);
    if (rd[ST_BUSY] !== 1'b0) bad_count++;
  endtask
  task results;
    $display("tests %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under this span
  initial begin
    #300us;
    bad_count++;
    results;
  end
  initial begin
    nrst = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; stuck = 0;
    bad_count = 0; tests_run = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    // the ready pin needs its two sync flops before status shows it
    repeat (4) @(posedge clk);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h40);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    wb(1'b1, REG_ADDR, 32'h3);
    wb(1'b1, REG_DATA, 32'h1234);
    run(OP_PROGRAM);
    chk(rd, 32'h42);
    chk({16'h0, i_fl.mem[3]}, 32'h1234);
    run(OP_READ);
    wb(1'b0, REG_DATA, 32'h0);
    chk(rd, 32'h1234);
    $display("test program done");
    run(OP_CHIP);
    chk(rd, 32'h42);
    // add-sector with the load window shut must be refused
    wb(1'b1, REG_CTRL, 32'h4);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h52);
    run(OP_READ);
    wb(1'b0, REG_DATA, 32'h0);
    chk(rd, 32'hffff);
    $display("test chip erase done");
    wb(1'b1, REG_ADDR, 32'h5);
    run(OP_SECTOR);
    chk(rd, 32'h22);
    run(OP_ADD);
    chk(rd, 32'h22);
    run(OP_SUSPEND);
    chk(rd, 32'h42);
    run(OP_RESUME);
    chk(rd, 32'h42);
    run(OP_WAIT);
    chk(rd, 32'h42);
    $display("test sector erase done");
    stuck <= 1'b1;
    run(OP_PROGRAM);
    chk(rd & 32'h3f, 32'h0e);
    chk(32'(i_fl.bc), 32'h0);
    stuck <= 1'b0;
    $display("test timeout done");
    results;
  end
endmodule // fes_flash_host_test
`default_nettype wire
